// ==== design/cmu_compare_state.sv ====
// compare channel state, passive select and multi-channel pattern block
//
// How it works
// - invert bit flips channel-3 compare signal
// - passive when state equals passive select
// - passive selects shadowed, load with timers
// - capture channels ignore passive select bits
// - compare state bits at 6,2,1,0
// - capture state set after selected edge
// - sampled position pins read at 5:3
// - modify clear bits 14,10,9,8 clear state
// - modify set bits 6,2,1,0 set state
// - set and clear together toggle state
// - gating enabled: pattern bit allows output
// - shadow pattern moves after trigger then sync
// - reminder set on trigger, cleared on transfer
// - direct sync transfers on trigger at once
// - shadow write with request bit asks update
// - trigger select decode, 11x does nothing
// - sync select decode, 11 does nothing
// - modulation control bit 7 enables gating
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "cmu_consts.svh"
module cmu_compare_state
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic [2:0] i_pos_pins,
  input wire logic [3:0] i_cmp_above,
  input wire logic [3:0] i_cmp_switch,
  input wire logic [2:0] i_capture_mode,
  input wire logic [2:0] i_capture_edge,
  input wire logic i_t12_shadow_load,
  input wire logic i_t13_shadow_load,
  input wire logic i_ch3_compare,
  input wire logic i_correct_pos_event,
  input wire logic i_t13_period_match,
  input wire logic i_t12_one_match_down,
  input wire logic i_ch1_compare_up,
  input wire logic i_t12_period_match_up,
  input wire logic i_t13_zero_match,
  input wire logic i_t12_zero_match_up,
  input wire logic [5:0] i_out_raw,
  output logic [5:0] o_out_gated,
  output logic [6:0] o_out_passive,
  output logic o_ch3_modulation,
  output logic o_irq
);
  //--------------------------------------------------
  // apb decode
  //--------------------------------------------------
  logic pready_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  wire access = i_psel && i_penable;
  wire done = access && pready_ff;
  wire hit_status = i_paddr == `CMU_OFF_STATUS;
  wire hit_modify = i_paddr == `CMU_OFF_MODIFY;
  wire hit_mcmctl = i_paddr == `CMU_OFF_MCMCTL;
  wire hit_shadow = i_paddr == `CMU_OFF_SHADOW;
  wire hit_active = i_paddr == `CMU_OFF_ACTIVE;
  wire hit_modctl = i_paddr == `CMU_OFF_MODCTL;
  wire hit_irqst = i_paddr == `CMU_OFF_IRQST;
  wire hit_irqmsk = i_paddr == `CMU_OFF_IRQMSK;
  wire mapped = hit_status | hit_modify | hit_mcmctl | hit_shadow | hit_active | hit_modctl | hit_irqst | hit_irqmsk;
  wire wr = done && i_pwrite && mapped;
  wire wr_status = wr && hit_status;
  wire wr_modify = wr && hit_modify;
  wire wr_mcmctl = wr && hit_mcmctl;
  wire wr_shadow = wr && hit_shadow;
  wire wr_modctl = wr && hit_modctl;
  wire wr_irqst = wr && hit_irqst;
  wire wr_irqmsk = wr && hit_irqmsk;

  //--------------------------------------------------
  // state registers
  //--------------------------------------------------
  logic invert_ff;
  logic [6:0] ps_shadow_ff, ps_active_ff;
  logic [3:0] state_ff;
  logic [3:0] nxt_state;
  logic [2:0] trig_sel_ff;
  logic [1:0] sync_sel_ff;
  logic [5:0] pat_shadow_ff, pat_active_ff;
  logic remind_ff;
  logic gate_en_ff;
  logic [1:0] irq_st_ff;
  logic [1:0] irq_msk_ff;
  logic [5:0] out_gated_ff;
  logic [6:0] out_passive_ff;
  logic ch3_mod_ff;
  logic irq_ff;
  logic [2:0] pos_sync;

  // position pins come from outside, synchronised first
  cmu_sync2 u_pos_sync
  (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_pos_pins),
    .o_sync(pos_sync)
  );

  //--------------------------------------------------
  // channel state set / clear / toggle
  //--------------------------------------------------
  wire [3:0] sw_set = {i_pwdata[`CMU_BIT_ST3], i_pwdata[2:0]} & {4{wr_modify}};
  wire [3:0] sw_clr = {i_pwdata[`CMU_BIT_CLR3], i_pwdata[`CMU_CLR_LO+2:`CMU_CLR_LO]} & {4{wr_modify}};
  wire [3:0] cap_mode = {1'b0, i_capture_mode};
  wire [3:0] cap_edge = {1'b0, i_capture_edge};

  // hardware switching wins over a software write in the same cycle
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1)
    begin : g_state
      always_comb
      begin
        if (cap_mode[ch] && cap_edge[ch])
          nxt_state[ch] = 1'b1;
        else if (!cap_mode[ch] && i_cmp_switch[ch])
          nxt_state[ch] = i_cmp_above[ch];
        else if (sw_set[ch] && sw_clr[ch])
          nxt_state[ch] = ~state_ff[ch];
        else if (sw_set[ch])
          nxt_state[ch] = 1'b1;
        else if (sw_clr[ch])
          nxt_state[ch] = 1'b0;
        else
          nxt_state[ch] = state_ff[ch];
      end
    end
  endgenerate

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      state_ff <= 4'h0;
    else
      state_ff <= nxt_state;
  end

  //--------------------------------------------------
  // passive select shadow and invert bit
  //--------------------------------------------------
  wire [6:0] ps_load = {i_t13_shadow_load, {6{i_t12_shadow_load}}};
  wire [6:0] nxt_ps_active = (ps_active_ff & ~ps_load) | (ps_shadow_ff & ps_load);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      invert_ff <= 1'b0;
      ps_shadow_ff <= `CMU_RST_PS;
      ps_active_ff <= `CMU_RST_PS;
    end
    else
    begin
      if (wr_status)
      begin
        invert_ff <= i_pwdata[`CMU_BIT_INVERT];
        ps_shadow_ff <= i_pwdata[`CMU_PS_HI:`CMU_PS_LO];
      end
      ps_active_ff <= nxt_ps_active;
    end
  end

  // per output: its channel state, capture flag
  wire [6:0] out_state = {state_ff[3], {2{state_ff[2]}}, {2{state_ff[1]}}, {2{state_ff[0]}}};
  wire [6:0] out_capt = {1'b0, {2{i_capture_mode[2]}}, {2{i_capture_mode[1]}}, {2{i_capture_mode[0]}}};
  wire [6:0] nxt_passive = ~(out_state ^ ps_active_ff) & ~out_capt;

  //--------------------------------------------------
  // multi-channel trigger and sync
  //--------------------------------------------------
  cmu_pkg::cmu_trig_e trig_sel;
  cmu_pkg::cmu_sync_e sync_sel;
  logic hw_trig;
  logic sync_ev;
  assign trig_sel = cmu_pkg::cmu_trig_e'(trig_sel_ff);
  assign sync_sel = cmu_pkg::cmu_sync_e'(sync_sel_ff);

  // reserved trigger codes select no event at all
  always_comb
  begin
    unique case (trig_sel)
      cmu_pkg::CMU_TRIG_NONE: hw_trig = 1'b0;
      cmu_pkg::CMU_TRIG_POS: hw_trig = i_correct_pos_event;
      cmu_pkg::CMU_TRIG_T13PM: hw_trig = i_t13_period_match;
      cmu_pkg::CMU_TRIG_T12OM: hw_trig = i_t12_one_match_down;
      cmu_pkg::CMU_TRIG_CH1UP: hw_trig = i_ch1_compare_up;
      cmu_pkg::CMU_TRIG_T12PM: hw_trig = i_t12_period_match_up;
      cmu_pkg::CMU_TRIG_RSV6: hw_trig = 1'b0;
      cmu_pkg::CMU_TRIG_RSV7: hw_trig = 1'b0;
    endcase
  end

  always_comb
  begin
    unique case (sync_sel)
      cmu_pkg::CMU_SYNC_DIRECT: sync_ev = 1'b0;
      cmu_pkg::CMU_SYNC_T13ZM: sync_ev = i_t13_zero_match;
      cmu_pkg::CMU_SYNC_T12ZM: sync_ev = i_t12_zero_match_up;
      cmu_pkg::CMU_SYNC_RSV: sync_ev = 1'b0;
    endcase
  end

  // a reserved sync code keeps hardware events away from the reminder
  wire sync_rsv = sync_sel == cmu_pkg::CMU_SYNC_RSV;
  wire sw_req = wr_shadow && i_pwdata[`CMU_BIT_STRQ];
  wire trig = (hw_trig && !sync_rsv) || sw_req;
  wire direct = sync_sel == cmu_pkg::CMU_SYNC_DIRECT;
  wire xfer = direct ? trig : ((remind_ff || trig) && sync_ev);
  // shadow written with request moves its new value
  wire [5:0] xfer_src = sw_req ? i_pwdata[5:0] : pat_shadow_ff;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      trig_sel_ff <= 3'h0;
      sync_sel_ff <= 2'h0;
      pat_shadow_ff <= `CMU_RST_PAT;
      pat_active_ff <= `CMU_RST_PAT;
      remind_ff <= 1'b0;
      gate_en_ff <= 1'b0;
    end
    else
    begin
      if (wr_mcmctl)
      begin
        trig_sel_ff <= i_pwdata[2:0];
        sync_sel_ff <= i_pwdata[`CMU_SYNC_LO+1:`CMU_SYNC_LO];
      end
      if (wr_shadow)
        pat_shadow_ff <= i_pwdata[5:0];
      if (xfer)
        pat_active_ff <= xfer_src;
      remind_ff <= !xfer && (remind_ff || trig);
      if (wr_modctl)
        gate_en_ff <= i_pwdata[`CMU_BIT_GATE];
    end
  end

  //--------------------------------------------------
  // interrupts: trigger seen, transfer done
  //--------------------------------------------------
  wire [1:0] irq_ev = {xfer, trig};
  wire [1:0] irq_clr = wr_irqst ? i_pwdata[1:0] : 2'h0;
  // set wins over a write-one clear in the same cycle
  wire [1:0] nxt_irq_st = (irq_st_ff & ~irq_clr) | irq_ev;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      irq_st_ff <= 2'h0;
      irq_msk_ff <= 2'h0;
    end
    else
    begin
      irq_st_ff <= nxt_irq_st;
      if (wr_irqmsk)
        irq_msk_ff <= i_pwdata[1:0];
    end
  end

  //--------------------------------------------------
  // registered outputs
  //--------------------------------------------------
  wire [5:0] nxt_gated = gate_en_ff ? (i_out_raw & pat_active_ff) : i_out_raw;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      out_gated_ff <= 6'h00;
      out_passive_ff <= 7'h00;
      ch3_mod_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      out_gated_ff <= nxt_gated;
      out_passive_ff <= nxt_passive;
      ch3_mod_ff <= i_ch3_compare ^ invert_ff;
      irq_ff <= |(irq_st_ff & irq_msk_ff);
    end
  end

  //--------------------------------------------------
  // apb read and answer
  //--------------------------------------------------
  wire [15:0] status_rd = {invert_ff, ps_active_ff, 1'b0, state_ff[3], pos_sync, state_ff[2:0]};
  wire [31:0] rd_mux =
    hit_status ? {16'h0000, status_rd} :
    hit_mcmctl ? {26'h0000000, sync_sel_ff, 1'b0, trig_sel_ff} :
    hit_shadow ? {26'h0000000, pat_shadow_ff} :
    hit_active ? {25'h0000000, remind_ff, pat_active_ff} :
    hit_modctl ? {24'h000000, gate_en_ff, 7'h00} :
    hit_irqst ? {30'h00000000, irq_st_ff} :
    hit_irqmsk ? {30'h00000000, irq_msk_ff} :
    32'h00000000;

  // one wait state keeps read data registered
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= access && !pready_ff;
      prdata_ff <= (access && !pready_ff && !i_pwrite) ? rd_mux : 32'h00000000;
      pslverr_ff <= access && !pready_ff && !mapped;
    end
  end

  assign o_pready = pready_ff;
  assign o_prdata = prdata_ff;
  assign o_pslverr = pslverr_ff;
  assign o_out_gated = out_gated_ff;
  assign o_out_passive = out_passive_ff;
  assign o_ch3_modulation = ch3_mod_ff;
  assign o_irq = irq_ff;

  //--------------------------------------------------
  // checks
  //--------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_direct_trig;
    direct && trig;
  endsequence

  chk_invert_ch3: assert property (##1 o_ch3_modulation == ($past(i_ch3_compare) ^ $past(invert_ff)))
    else $error("channel 3 modulation inversion wrong");
  chk_passive_level: assert property (!out_capt[0] |=>
    o_out_passive[0] == ($past(state_ff[0]) == $past(ps_active_ff[0])))
    else $error("passive indication wrong");
  chk_ps_shadow: assert property (!i_t12_shadow_load |=> $stable(ps_active_ff[5:0]))
    else $error("passive select changed without load");
  chk_capture_ignore: assert property (i_capture_mode[0] |=> o_out_passive[1:0] == 2'b00)
    else $error("capture channel used passive select");
  chk_toggle_state: assert property (sw_set[0] && sw_clr[0] && !cap_mode[0] && !i_cmp_switch[0]
    |=> state_ff[0] != $past(state_ff[0]))
    else $error("set and clear did not toggle");
  chk_direct_xfer: assert property (s_direct_trig |=> pat_active_ff == $past(xfer_src) && !remind_ff)
    else $error("direct transfer missed");
  chk_remind_hold: assert property (remind_ff && !sync_ev && !direct |=> remind_ff)
    else $error("reminder lost before transfer");
  chk_reserved_trig: assert property (trig_sel_ff[2:1] == 2'b11 && !sw_req |=> $stable(pat_active_ff))
    else $error("reserved trigger caused transfer");
  chk_gate_output: assert property (gate_en_ff |=> (o_out_gated & ~$past(pat_active_ff)) == 6'h00)
    else $error("gated output not masked");
endmodule

// ==== design/cmu_consts.svh ====
// register offsets, field positions and reset values of the compare state block
`ifndef CMU_CONSTS_SVH
`define CMU_CONSTS_SVH
`define CMU_ADDR_W 16
`define CMU_OFF_STATUS 16'hEAA0
`define CMU_OFF_MODIFY 16'hEAA8
`define CMU_OFF_MCMCTL 16'hEAB0
`define CMU_OFF_SHADOW 16'hEAB4
`define CMU_OFF_ACTIVE 16'hEAB8
`define CMU_OFF_MODCTL 16'hEABC
`define CMU_OFF_IRQST 16'hEAC0
`define CMU_OFF_IRQMSK 16'hEAC4
`define CMU_BIT_INVERT 15
`define CMU_PS_LO 8
`define CMU_PS_HI 14
`define CMU_POS_LO 3
`define CMU_BIT_ST3 6
`define CMU_CLR_LO 8
`define CMU_BIT_CLR3 14
`define CMU_BIT_STRQ 7
`define CMU_BIT_REMIND 6
`define CMU_BIT_GATE 7
`define CMU_SYNC_LO 4
`define CMU_IRQ_TRIG 0
`define CMU_IRQ_XFER 1
`define CMU_RST_PS 7'h00
`define CMU_RST_PAT 6'h00
`endif

// ==== design/cmu_pkg.sv ====
// types shared by the compare state and multi-channel pattern logic
package cmu_pkg;
  typedef enum logic [2:0]
  {
    CMU_TRIG_NONE = 3'b000,
    CMU_TRIG_POS = 3'b001,
    CMU_TRIG_T13PM = 3'b010,
    CMU_TRIG_T12OM = 3'b011,
    CMU_TRIG_CH1UP = 3'b100,
    CMU_TRIG_T12PM = 3'b101,
    CMU_TRIG_RSV6 = 3'b110,
    CMU_TRIG_RSV7 = 3'b111
  } cmu_trig_e;
  typedef enum logic [1:0]
  {
    CMU_SYNC_DIRECT = 2'b00,
    CMU_SYNC_T13ZM = 2'b01,
    CMU_SYNC_T12ZM = 2'b10,
    CMU_SYNC_RSV = 2'b11
  } cmu_sync_e;
endpackage

// ==== design/cmu_sync2.sv ====
// two flip-flop synchroniser for the position sensor pins
`timescale 1ns/1ps
module cmu_sync2
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_async,
  output logic [2:0] o_sync
);
  logic [2:0] meta_ff;
  logic [2:0] hold_ff;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta_ff <= 3'h0;
      hold_ff <= 3'h0;
    end
    else
    begin
      meta_ff <= i_async;
      hold_ff <= meta_ff;
    end
  end

  assign o_sync = hold_ff;
endmodule

// ==== verif/cmu_compare_state_tb_top.sv ====
// self-checking bench of the compare state and multi-channel pattern block
`timescale 1ns/1ps
`include "cmu_consts.svh"
module cmu_compare_state_tb_top;
  logic clk, rst, psel, pen, pwr, pready, pslverr, irq, c3in, c3mod, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] pos, capm, cape;
  logic [3:0] above, sw;
  logic [1:0] shl, syn;
  logic [4:0] trg;
  logic [5:0] raw, gated;
  logic [6:0] passive, pins;
  int error_cnt, cmp_count;
  // ------------------------------------------------------------
  // design and far side
  // ------------------------------------------------------------
  cmu_compare_state cmu_compare_state_i (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_pos_pins(pos), .i_cmp_above(above), .i_cmp_switch(sw),
    .i_capture_mode(capm), .i_capture_edge(cape), .i_t12_shadow_load(shl[0]),
    .i_t13_shadow_load(shl[1]), .i_ch3_compare(c3in), .i_correct_pos_event(trg[0]),
    .i_t13_period_match(trg[1]), .i_t12_one_match_down(trg[2]), .i_ch1_compare_up(trg[3]),
    .i_t12_period_match_up(trg[4]), .i_t13_zero_match(syn[0]), .i_t12_zero_match_up(syn[1]),
    .i_out_raw(raw), .o_out_gated(gated), .o_out_passive(passive), .o_ch3_modulation(c3mod),
    .o_irq(irq));
  cmu_drive_stage cmu_drive_stage_i (.i_clk(clk), .i_gated(gated), .i_passive(passive),
    .i_ch3_mod(c3mod), .o_pin(pins));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // one apb transfer; the wait for ready is bounded so a dead slave ends the run
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      close_out();
    end
    else
    begin
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task pt(input logic [4:0] v);
    @(posedge clk);
    trg <= v;
    @(posedge clk);
    trg <= 5'h00;
  endtask
  task psy(input logic [1:0] v);
    @(posedge clk);
    syn <= v;
    @(posedge clk);
    syn <= 2'h0;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task sc_state;
    rd(16'hEAFC, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(`CMU_OFF_MODIFY, 32'h0047);
    rd(`CMU_OFF_STATUS, 32'h0047);
    wr(`CMU_OFF_MODIFY, 32'h0200);
    rd(`CMU_OFF_STATUS, 32'h0045);
    wr(`CMU_OFF_MODIFY, 32'h4141);
    rd(`CMU_OFF_STATUS, 32'h0004);
    wr(`CMU_OFF_MODIFY, 32'h4700);
    above <= 4'hF;
    @(posedge clk) sw <= 4'b1001;
    @(posedge clk) sw <= 4'h0;
    rd(`CMU_OFF_STATUS, 32'h0041);
    above <= 4'h0;
    @(posedge clk) sw <= 4'b1001;
    @(posedge clk) sw <= 4'h0;
    rd(`CMU_OFF_STATUS, 32'h0000);
    capm <= 3'b001;
    @(posedge clk) cape <= 3'b001;
    @(posedge clk) cape <= 3'b000;
    rd(`CMU_OFF_STATUS, 32'h0001);
    // state and select both 0 here, so only capture mode keeps bits 1:0 low
    wr(`CMU_OFF_MODIFY, 32'h0100);
    repeat (2) @(posedge clk);
    chk({25'h0, passive}, 32'h7C);
    capm <= 3'b000;
    $display("test state done");
  endtask
  task sc_passive;
    wr(`CMU_OFF_STATUS, 32'h7F00);
    rd(`CMU_OFF_STATUS, 32'h0000);
    chk({25'h0, passive}, 32'h7F);
    @(posedge clk) shl <= 2'b01;
    @(posedge clk) shl <= 2'b00;
    rd(`CMU_OFF_STATUS, 32'h3F00);
    @(posedge clk) shl <= 2'b10;
    @(posedge clk) shl <= 2'b00;
    rd(`CMU_OFF_STATUS, 32'h7F00);
    chk({25'h0, passive}, 32'h00);
    wr(`CMU_OFF_MODIFY, 32'h0040);
    repeat (3) @(posedge clk);
    chk({25'h0, passive}, 32'h40);
    c3in <= 1'b1;
    wr(`CMU_OFF_STATUS, 32'hFF00);
    repeat (3) @(posedge clk);
    chk({31'h0, c3mod}, 32'h0);
    rd(`CMU_OFF_STATUS, 32'hFF40);
    wr(`CMU_OFF_STATUS, 32'h7F00);
    pos <= 3'b101;
    repeat (4) @(posedge clk);
    chk({31'h0, c3mod}, 32'h1);
    rd(`CMU_OFF_STATUS, 32'h7F68);
    $display("test passive done");
  endtask
  task sc_pattern;
    wr(`CMU_OFF_MCMCTL, 32'h12);
    wr(`CMU_OFF_SHADOW, 32'h2A);
    pt(5'h02);
    rd(`CMU_OFF_ACTIVE, 32'h40);
    psy(2'b01);
    rd(`CMU_OFF_ACTIVE, 32'h2A);
    raw <= 6'h3F;
    wr(`CMU_OFF_MODCTL, 32'h80);
    repeat (3) @(posedge clk);
    chk({26'h0, gated}, 32'h2A);
    // channel 3 is passive here, so its pin shows the passive level
    chk({25'h0, pins}, 32'h2A);
    wr(`CMU_OFF_MODCTL, 32'h00);
    repeat (3) @(posedge clk);
    chk({26'h0, gated}, 32'h3F);
    wr(`CMU_OFF_MCMCTL, 32'h25);
    wr(`CMU_OFF_SHADOW, 32'h15);
    pt(5'h10);
    rd(`CMU_OFF_ACTIVE, 32'h6A);
    psy(2'b10);
    rd(`CMU_OFF_ACTIVE, 32'h15);
    wr(`CMU_OFF_MCMCTL, 32'h32);
    wr(`CMU_OFF_SHADOW, 32'h0F);
    pt(5'h02);
    psy(2'b11);
    rd(`CMU_OFF_ACTIVE, 32'h15);
    $display("test pattern done");
  endtask
  task sc_direct;
    logic [5:0] v;
    for (int k = 1; k < 6; k++)
    begin
      v = 6'(k * 13);
      wr(`CMU_OFF_MCMCTL, 32'(k));
      wr(`CMU_OFF_SHADOW, {26'h0, v});
      pt(5'(1 << (k - 1)));
      rd(`CMU_OFF_ACTIVE, {26'h0, v});
    end
    for (int i = 0; i < 6; i++)
      if (i == 0 || i > 3)
      begin
        wr(`CMU_OFF_MCMCTL, (i == 0) ? 32'h0 : 32'(i + 2));
        wr(`CMU_OFF_SHADOW, 32'h3F);
        pt(5'h1F);
        rd(`CMU_OFF_ACTIVE, 32'h01);
      end
    wr(`CMU_OFF_MCMCTL, 32'h0);
    wr(`CMU_OFF_SHADOW, 32'hB3);
    rd(`CMU_OFF_ACTIVE, 32'h33);
    $display("test direct done");
  endtask
  task sc_irq;
    wr(`CMU_OFF_IRQST, 32'h3);
    rd(`CMU_OFF_IRQST, 32'h0);
    wr(`CMU_OFF_IRQMSK, 32'h2);
    wr(`CMU_OFF_MCMCTL, 32'h1);
    pt(5'h01);
    rd(`CMU_OFF_IRQST, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(`CMU_OFF_IRQMSK, 32'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(`CMU_OFF_IRQST, 32'h3);
    rd(`CMU_OFF_IRQST, 32'h0);
    $display("test irq done");
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    {rst, psel, pen, pwr, c3in} = 5'b10000;
    {paddr, pwdata, pos, capm, cape, above, sw, shl, syn, trg, raw} = '0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    sc_state();
    sc_passive();
    sc_pattern();
    sc_direct();
    sc_irq();
    close_out();
  end
endmodule

// ==== verif/cmu_drive_stage.sv ====
// model of the output modulation stage fed by the gated and passive outputs
`timescale 1ns/1ps
module cmu_drive_stage
#(
  parameter logic PASSIVE_LEVEL = 1'b0
)
(
  input wire logic i_clk,
  input wire logic [5:0] i_gated,
  input wire logic [6:0] i_passive,
  input wire logic i_ch3_mod,
  output logic [6:0] o_pin
);
  // ------------------------------------------------------------
  // pin levels
  // ------------------------------------------------------------
  // a passive output forces the level, so a stale pattern never reaches the switch
  always_ff @(posedge i_clk)
  begin
    for (int k = 0; k < 6; k++)
      o_pin[k] <= i_passive[k] ? PASSIVE_LEVEL : i_gated[k];
    o_pin[6] <= i_passive[6] ? PASSIVE_LEVEL : i_ch3_mod;
  end
endmodule
